/* File: umpc_params.svh */
// constants for the modem pin control serial port
`ifndef UMPC_PARAMS_SVH
`define UMPC_PARAMS_SVH
`define UMPC_CLK_HZ 100000000
`define UMPC_BAUD_DEFAULT 115200
`define UMPC_DATA_BITS 8
`define UMPC_FIFO_DEPTH 8
`define UMPC_MARK_LEVEL 1'b1
`define UMPC_SPACE_LEVEL 1'b0
`define UMPC_RTS_INACTIVE 1'b1
`define UMPC_RTS_ACTIVE 1'b0
`endif

/* File: umpc_pkg.sv */
// types for the modem pin control serial port
`default_nettype none
package umpc_pkg;
  typedef enum logic [3:0] {
    UMPC_TX_IDLE = 4'h1,
    UMPC_TX_START = 4'h2,
    UMPC_TX_DATA = 4'h4,
    UMPC_TX_STOP = 4'h8
  } umpc_tx_state_type;
  typedef enum logic [3:0] {
    UMPC_RX_IDLE = 4'h1,
    UMPC_RX_START = 4'h2,
    UMPC_RX_DATA = 4'h4,
    UMPC_RX_STOP = 4'h8
  } umpc_rx_state_type;
endpackage
`default_nettype wire

/* File: umpc_fifo.sv */
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module umpc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
  assign out_valid_o = (count_reg != '0);
  assign out_data_o = mem_reg[rptr_reg];
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_reg[wptr_reg] <= in_data_i;
    end
  end
  // ready is registered so it can leave the top straight from a flop
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
      in_ready_o <= 1'b1;
    end else begin
      if (push) wptr_reg <= wptr_reg + AW'(1);
      if (pop) rptr_reg <= rptr_reg + AW'(1);
      count_reg <= count_next;
      in_ready_o <= (count_next != (AW+1)'(DEPTH));
    end
  end
endmodule
`default_nettype wire

/* File: umpc_uart.sv */
// serial port with modem handshake pins and transmit fifo
`timescale 1ns/10ps
`default_nettype none
`include "umpc_params.svh"
module umpc_uart #(
  parameter int BAUD_DIV = `UMPC_CLK_HZ / `UMPC_BAUD_DEFAULT
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire logic rts_request_i,
  input wire logic loop_mode_i,
  input wire logic serial_rx_in_i,
  input wire logic clear_to_send_in_n_i,
  output logic serial_tx_out_o,
  output logic request_to_send_out_n_o,
  output logic clear_to_send_status_o,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic rx_frame_err_o
);
  // ----------------------------------------
  // bit timing
  // ----------------------------------------
  localparam int HALF_DIV = BAUD_DIV / 2;
  logic [15:0] tx_cnt_reg;
  logic [15:0] rx_cnt_reg;
  logic [2:0] tx_bit_reg;
  logic [2:0] rx_bit_reg;
  logic [7:0] tx_shift_reg;
  logic [7:0] rx_shift_reg;
  wire tx_tick = (tx_cnt_reg == 16'(BAUD_DIV - 1));
  umpc_pkg::umpc_tx_state_type tx_state_reg;
  umpc_pkg::umpc_rx_state_type rx_state_reg;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic rx_meta_reg, rx_sync_reg, cts_meta_reg, cts_sync_reg;
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rx_meta_reg <= `UMPC_MARK_LEVEL;
      rx_sync_reg <= `UMPC_MARK_LEVEL;
      cts_meta_reg <= 1'b1;
      cts_sync_reg <= 1'b1;
    end else begin
      rx_meta_reg <= serial_rx_in_i;
      rx_sync_reg <= rx_meta_reg;
      cts_meta_reg <= clear_to_send_in_n_i;
      cts_sync_reg <= cts_meta_reg;
    end
  end

  // loopback feeds the receiver from the transmitter
  wire rx_line = loop_mode_i ? serial_tx_out_o : rx_sync_reg;

  // ----------------------------------------
  // handshake pins
  // ----------------------------------------
  wire rts_next = loop_mode_i ? `UMPC_RTS_INACTIVE :
                  (rts_request_i ? `UMPC_RTS_ACTIVE :
                   `UMPC_RTS_INACTIVE);
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      request_to_send_out_n_o <= `UMPC_RTS_INACTIVE;
      clear_to_send_status_o <= 1'b0;
    end else begin
      request_to_send_out_n_o <= rts_next;
      clear_to_send_status_o <= ~cts_sync_reg;
    end
  end

  // ----------------------------------------
  // transmit fifo
  // ----------------------------------------
  wire [7:0] fifo_data;
  wire fifo_valid;
  wire fifo_pop = fifo_valid && (tx_state_reg == umpc_pkg::UMPC_TX_IDLE);
  wire fifo_in_ready;
  umpc_fifo #(.WIDTH(`UMPC_DATA_BITS), .DEPTH(`UMPC_FIFO_DEPTH)) u_fifo (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .in_data_i(tx_data_i),
    .in_valid_i(tx_valid_i),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop)
  );
  assign tx_ready_o = fifo_in_ready;

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      tx_state_reg <= umpc_pkg::UMPC_TX_IDLE;
      serial_tx_out_o <= `UMPC_MARK_LEVEL;
      tx_cnt_reg <= 16'h0000;
      tx_bit_reg <= 3'h0;
      tx_shift_reg <= 8'h00;
    end else begin
      tx_cnt_reg <= (tx_tick || tx_state_reg == umpc_pkg::UMPC_TX_IDLE) ?
                    16'h0000 : tx_cnt_reg + 16'h0001;
      case (tx_state_reg)
        umpc_pkg::UMPC_TX_IDLE: begin
          serial_tx_out_o <= `UMPC_MARK_LEVEL;
          if (fifo_pop) begin
            tx_shift_reg <= fifo_data;
            serial_tx_out_o <= `UMPC_SPACE_LEVEL;
            tx_state_reg <= umpc_pkg::UMPC_TX_START;
          end
        end
        umpc_pkg::UMPC_TX_START: begin
          if (tx_tick) begin
            serial_tx_out_o <= tx_shift_reg[0];
            tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
            tx_bit_reg <= 3'h0;
            tx_state_reg <= umpc_pkg::UMPC_TX_DATA;
          end
        end
        umpc_pkg::UMPC_TX_DATA: begin
          if (tx_tick) begin
            if (tx_bit_reg == 3'h7) begin
              serial_tx_out_o <= `UMPC_MARK_LEVEL;
              tx_state_reg <= umpc_pkg::UMPC_TX_STOP;
            end else begin
              serial_tx_out_o <= tx_shift_reg[0];
              tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
              tx_bit_reg <= tx_bit_reg + 3'h1;
            end
          end
        end
        umpc_pkg::UMPC_TX_STOP: begin
          if (tx_tick) tx_state_reg <= umpc_pkg::UMPC_TX_IDLE;
        end
        default: begin
          tx_state_reg <= umpc_pkg::UMPC_TX_IDLE;
          serial_tx_out_o <= `UMPC_MARK_LEVEL;
        end
      endcase
    end
  end

  // ----------------------------------------
  // receiver, samples mid-bit
  // ----------------------------------------
  wire rx_half = (rx_cnt_reg == 16'(HALF_DIV - 1));
  wire rx_full = (rx_cnt_reg == 16'(BAUD_DIV - 1));
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rx_state_reg <= umpc_pkg::UMPC_RX_IDLE;
      rx_cnt_reg <= 16'h0000;
      rx_bit_reg <= 3'h0;
      rx_shift_reg <= 8'h00;
      rx_data_o <= 8'h00;
      rx_valid_o <= 1'b0;
      rx_frame_err_o <= 1'b0;
    end else begin
      rx_valid_o <= 1'b0;
      rx_frame_err_o <= 1'b0;
      rx_cnt_reg <= rx_cnt_reg + 16'h0001;
      case (rx_state_reg)
        umpc_pkg::UMPC_RX_IDLE: begin
          rx_cnt_reg <= 16'h0000;
          if (rx_line == `UMPC_SPACE_LEVEL) begin
            rx_state_reg <= umpc_pkg::UMPC_RX_START;
          end
        end
        umpc_pkg::UMPC_RX_START: begin
          if (rx_half) begin
            rx_cnt_reg <= 16'h0000;
            rx_bit_reg <= 3'h0;
            rx_state_reg <= rx_line ? umpc_pkg::UMPC_RX_IDLE :
                            umpc_pkg::UMPC_RX_DATA;
          end
        end
        umpc_pkg::UMPC_RX_DATA: begin
          if (rx_full) begin
            rx_cnt_reg <= 16'h0000;
            rx_shift_reg <= {rx_line, rx_shift_reg[7:1]};
            rx_bit_reg <= rx_bit_reg + 3'h1;
            if (rx_bit_reg == 3'h7) rx_state_reg <= umpc_pkg::UMPC_RX_STOP;
          end
        end
        umpc_pkg::UMPC_RX_STOP: begin
          if (rx_full) begin
            // a bad stop bit drops the byte, last good one stands
            if (rx_line) rx_data_o <= rx_shift_reg;
            rx_valid_o <= rx_line;
            rx_frame_err_o <= ~rx_line;
            rx_state_reg <= umpc_pkg::UMPC_RX_IDLE;
          end
        end
        default: rx_state_reg <= umpc_pkg::UMPC_RX_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: umpc_modem.sv */
// far-side modem model for the serial port
`timescale 1ns/10ps
`default_nettype none
module umpc_modem #(
  parameter int BAUD_DIV = 16
) (
  input wire logic core_clk_i,
  input wire logic tx_line_i,
  input wire logic cts_ready_i,
  output logic rx_line_o,
  output logic cts_n_o
);
  logic [7:0] got_q[$];
  logic [7:0] b;
  // ------------
  // line drivers
  // ------------
  assign cts_n_o = !cts_ready_i;
  initial rx_line_o = 1'b1;
  task automatic send(input logic [7:0] d, input logic stop);
    logic [9:0] f;
    f = {stop, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_line_o = f[i];
      repeat (BAUD_DIV) @(negedge core_clk_i);
    end
    rx_line_o = 1'b1;
  endtask
  // decode at mid-bit, keep only good stop bits
  always begin
    @(negedge core_clk_i iff tx_line_i === 1'b0);
    repeat (BAUD_DIV / 2) @(negedge core_clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BAUD_DIV) @(negedge core_clk_i);
      b[i] = tx_line_i;
    end
    repeat (BAUD_DIV) @(negedge core_clk_i);
    if (tx_line_i === 1'b1)
      got_q.push_back(b);
  end
endmodule
`default_nettype wire

/* File: umpc_checker.sv */
// assertions on the serial port pins
`timescale 1ns/10ps
`default_nettype none
module umpc_checker #(
  parameter int BAUD_DIV = 16
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic rts_request_i,
  input wire logic loop_mode_i,
  input wire logic clear_to_send_in_n_i,
  input wire logic serial_tx_out_o,
  input wire logic request_to_send_out_n_o,
  input wire logic clear_to_send_status_o,
  input wire logic rx_valid_o
);
  int fc;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  // ----------
  // properties
  // ----------
  // countdown over one frame from its start bit
  always_ff @(posedge core_clk_i) begin
    if (srst_i)
      fc <= 0;
    else if (fc != 0)
      fc <= fc - 1;
    else if (!serial_tx_out_o)
      fc <= 10 * BAUD_DIV - 1;
  end
  property p_tx_rst; $past(srst_i) |-> serial_tx_out_o; endproperty
  a_tx_rst: assert property (p_tx_rst) else $error("tx not idle");
  property p_rts_rst; $past(srst_i) |-> request_to_send_out_n_o; endproperty
  a_rts_rst: assert property (p_rts_rst) else $error("rts active");
  property p_rts_loop; loop_mode_i |=> request_to_send_out_n_o; endproperty
  a_rts_loop: assert property (p_rts_loop) else $error("rts in loop");
  property p_rts_req;
    !loop_mode_i |=> request_to_send_out_n_o == !$past(rts_request_i);
  endproperty
  a_rts_req: assert property (p_rts_req) else $error("rts level");
  property p_cts_on;
    !clear_to_send_in_n_i [*4] |=> clear_to_send_status_o;
  endproperty
  a_cts_on: assert property (p_cts_on) else $error("cts not shown");
  property p_cts_off;
    clear_to_send_in_n_i [*4] |=> !clear_to_send_status_o;
  endproperty
  a_cts_off: assert property (p_cts_off) else $error("cts stuck");
  property p_start; fc > 9 * BAUD_DIV |-> !serial_tx_out_o; endproperty
  a_start: assert property (p_start) else $error("start bit short");
  property p_stop; fc inside {[1:BAUD_DIV]} |-> serial_tx_out_o; endproperty
  a_stop: assert property (p_stop) else $error("stop bit low");
  c_frame: cover property (fc == 1);
  c_loop: cover property (loop_mode_i && rts_request_i);
  c_rx: cover property (rx_valid_o);
endmodule
bind umpc_uart umpc_checker #(.BAUD_DIV(BAUD_DIV)) chk (
  .core_clk_i(core_clk_i),
  .srst_i(srst_i),
  .rts_request_i(rts_request_i),
  .loop_mode_i(loop_mode_i),
  .clear_to_send_in_n_i(clear_to_send_in_n_i),
  .serial_tx_out_o(serial_tx_out_o),
  .request_to_send_out_n_o(request_to_send_out_n_o),
  .clear_to_send_status_o(clear_to_send_status_o),
  .rx_valid_o(rx_valid_o)
);
`default_nettype wire

/* File: umpc_tb.sv */
// testbench for the modem pin control serial port
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 0, rst = 1, txv = 0, rts = 0, loop = 0, rdy = 0;
  logic [7:0] txd = 8'h00, rx_last = 8'h00, rxd;
  logic tx, rtsn, sts, txr, rxl, ctsn, rxv, ferr;
  int mismatches = 0, samples_checked = 0, rx_cnt = 0, err_cnt = 0;
  always #5 clk = ~clk;
  umpc_uart #(.BAUD_DIV(16)) DUT (.core_clk_i(clk), .srst_i(rst),
    .tx_data_i(txd), .tx_valid_i(txv), .tx_ready_o(txr),
    .rts_request_i(rts), .loop_mode_i(loop), .serial_rx_in_i(rxl),
    .clear_to_send_in_n_i(ctsn), .serial_tx_out_o(tx),
    .request_to_send_out_n_o(rtsn), .clear_to_send_status_o(sts),
    .rx_data_o(rxd), .rx_valid_o(rxv), .rx_frame_err_o(ferr));
  umpc_modem #(.BAUD_DIV(16)) MODEM (.core_clk_i(clk), .tx_line_i(tx),
    .cts_ready_i(rdy), .rx_line_o(rxl), .cts_n_o(ctsn));
  // -----
  // tests
  // -----
  always @(negedge clk) begin
    if (rxv === 1'b1) begin
      rx_cnt++;
      rx_last = rxd;
    end
    if (ferr === 1'b1)
      err_cnt++;
  end
  task automatic check(input string n, input logic [7:0] e,
                       input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic test_done;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic t_reset;
    rts = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    check("tx", 8'h01, 8'(tx));
    check("rts_n", 8'h01, 8'(rtsn));
    rst = 1'b0;
    $display("reset test done");
  endtask
  task automatic t_rts;
    repeat (2) @(negedge clk);
    check("rts_n on", 8'h00, 8'(rtsn));
    loop = 1'b1;
    repeat (2) @(negedge clk);
    check("rts_n loop", 8'h01, 8'(rtsn));
    loop = 1'b0;
    rts = 1'b0;
    repeat (2) @(negedge clk);
    check("rts_n off", 8'h01, 8'(rtsn));
    $display("rts test done");
  endtask
  task automatic t_cts;
    rdy = 1'b1;
    repeat (4) @(negedge clk);
    check("cts on", 8'h01, 8'(sts));
    rdy = 1'b0;
    repeat (4) @(negedge clk);
    check("cts off", 8'h00, 8'(sts));
    $display("cts test done");
  endtask
  task automatic t_tx;
    int n;
    n = 0;
    txv = 1'b1;
    while (n < 12 && txr === 1'b1) begin
      txd = 8'h30 + 8'(n);
      @(negedge clk);
      n++;
    end
    txv = 1'b0;
    check("refused", 8'h00, 8'(txr));
    for (int w = 0; w < 3000 && MODEM.got_q.size() < n; w++)
      @(negedge clk);
    check("count", 8'(n), 8'(MODEM.got_q.size()));
    foreach (MODEM.got_q[i])
      check("byte", 8'h30 + 8'(i), MODEM.got_q[i]);
    check("drained", 8'h01, 8'(txr));
    $display("tx test done");
  endtask
  task automatic t_rx;
    int c, d;
    c = rx_cnt;
    d = rx_cnt + 1;
    MODEM.send(8'hA5, 1'b1);
    repeat (4) @(negedge clk);
    check("rx count", 8'(c + 1), 8'(rx_cnt));
    check("rx byte", 8'hA5, rx_last);
    c = err_cnt;
    MODEM.send(8'h5A, 1'b0);
    repeat (20) @(negedge clk);
    check("frame err", 8'(c + 1), 8'(err_cnt));
    check("rx dropped", 8'(d), 8'(rx_cnt));
    check("rx data kept", 8'hA5, rxd);
    $display("rx test done");
  endtask
  task automatic t_loop;
    int c;
    c = rx_cnt;
    loop = 1'b1;
    rts = 1'b1;
    txd = 8'hC3;
    txv = 1'b1;
    @(negedge clk);
    txv = 1'b0;
    repeat (200) @(negedge clk);
    check("loop count", 8'(c + 1), 8'(rx_cnt));
    check("loop byte", 8'hC3, rx_last);
    check("rts_n loop req", 8'h01, 8'(rtsn));
    loop = 1'b0;
    rts = 1'b0;
    $display("loop test done");
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_reset;
    t_rts;
    t_cts;
    t_tx;
    t_rx;
    t_loop;
    test_done;
  end
  // about five times the expected run
  initial begin
    #100000;
    mismatches++;
    test_done;
  end
endmodule
`default_nettype wire
